// ===== shared/spmc_pkg.sv
// Constants and carrier types for the sensor power, mode and calibration registers.
// Assumes a byte-wide register port driven by the serial bus front end on the same clock.
package spmc_pkg;
  localparam logic [7:0] SPMC_ADDR_CALIB_STATUS = 8'h6D;
  localparam logic [7:0] SPMC_ADDR_FUNC_ENABLE  = 8'h80;
  localparam logic [7:0] SPMC_ADDR_MEAS_SELECT  = 8'h81;
  localparam logic [7:0] SPMC_ADDR_FLICK_CONFIG = 8'h82;

  localparam int SPMC_BIT_BASELINE = 2;
  localparam int SPMC_BIT_OFFSET   = 1;
  localparam int SPMC_BIT_CALDONE  = 0;
  localparam int SPMC_BIT_POWER_ON = 0;
  localparam int SPMC_BIT_PROX_ON  = 3;
  localparam int SPMC_BIT_LIGHT_ON = 4;
  localparam int SPMC_BIT_FLICK_ON = 6;
  localparam int SPMC_BIT_SYNC     = 6;
  localparam int SPMC_BIT_CHAIN    = 1;
  localparam int SPMC_BIT_LDIODE   = 0;
  localparam int SPMC_BIT_FPATH    = 6;

  localparam logic [7:0] SPMC_MASK_CALIB  = 8'h07;
  localparam logic [7:0] SPMC_MASK_ENABLE = 8'h59;
  localparam logic [7:0] SPMC_MASK_MEAS   = 8'h4F;
  localparam logic [7:0] SPMC_MASK_FLICK  = 8'h7F;
  localparam logic [1:0] SPMC_PROX_DIODE_ON = 2'h3;

  localparam logic [7:0] SPMC_RST_CALIB  = 8'h00;
  localparam logic [7:0] SPMC_RST_ENABLE = 8'h00;
  localparam logic [7:0] SPMC_RST_MEAS   = 8'h00;
  localparam logic [7:0] SPMC_RST_FLICK  = 8'h00;

  typedef enum logic [2:0] {
    SPMC_BUF_OFF     = 3'h0,
    SPMC_BUF_W32     = 3'h1,
    SPMC_BUF_LIGHT16 = 3'h2,
    SPMC_BUF_FLICK16 = 3'h3,
    SPMC_BUF_FLICK8  = 3'h4
  } spmc_buf_fmt_e;

  // One-hot start gating for the light, proximity and flicker measurements
  typedef enum logic [2:0] {
    SPMC_ST_IDLE = 3'b001,
    SPMC_ST_WAIT = 3'b010,
    SPMC_ST_RUN  = 3'b100
  } spmc_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spmc_reg_req_s;

  typedef struct packed {
    logic       osc_run;
    logic       flicker_on;
    logic       light_sense_on;
    logic       prox_sense_on;
    logic       measure_go;
    logic       prox_photodiode_on;
    logic       light_chain_select;
    logic       light_photodiode_on;
    logic       flicker_path_select;
    logic [2:0] buf_fmt;
    logic       buf_fmt_bad;
  } spmc_ctrl_s;
endpackage

// ===== verilog/spmc_regs.sv
// Register bank for power, function enables, measurement selection and calibration status.
// Assumes a synchronous byte register port from a serial bus front end and event pulses
// from the proximity and calibration engines, all on clk_in.
`timescale 1ns/1ps
`default_nettype none
module spmc_regs
  import spmc_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire spmc_reg_req_s req_in,
  output var  logic [7:0]    rdata_out,
  output var  logic          rvalid_out,
  input  wire logic          vsync_in,
  input  wire logic          auto_baseline_on_in,
  input  wire logic          auto_offset_on_in,
  input  wire logic          calib_int_en_in,
  input  wire logic          baseline_lowered_in,
  input  wire logic          offset_lowered_in,
  input  wire logic          calib_complete_in,
  output var  spmc_ctrl_s    ctrl_out,
  output var  logic [7:0]    calib_status_out,
  output var  logic          calibration_interrupt_out
);

  logic [7:0]  calibration_status;
  logic [7:0]  function_enable;
  logic [7:0]  measurement_select;
  logic [7:0]  flicker_buffer_config;
  logic        vsync_meta;
  logic        vsync_sync;
  logic        vsync_prev;
  logic        vsync_rise;
  logic        any_on;
  logic [7:0]  next_enable;
  logic [7:0]  next_status;
  logic        base_evt;
  logic        offs_evt;
  spmc_state_e state;
  spmc_state_e next_state;

  function automatic logic hit(input spmc_reg_req_s r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Display sync arrives from a pin, so it is synchronised before edge detection
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vsync_meta <= 1'b0;
      vsync_sync <= 1'b0;
      vsync_prev <= 1'b0;
    end else begin
      vsync_meta <= vsync_in;
      vsync_sync <= vsync_meta;
      vsync_prev <= vsync_sync;
    end
  end

  assign vsync_rise = vsync_sync & ~vsync_prev;

  // Clearing power on also drops light and proximity enables in the same write
  always_comb begin
    next_enable = req_in.wdata & SPMC_MASK_ENABLE;
    if (!req_in.wdata[SPMC_BIT_POWER_ON]) begin
      next_enable[SPMC_BIT_PROX_ON]  = 1'b0;
      next_enable[SPMC_BIT_LIGHT_ON] = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      function_enable <= SPMC_RST_ENABLE;
    end else if (hit(req_in, SPMC_ADDR_FUNC_ENABLE)) begin
      function_enable <= next_enable;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      measurement_select <= SPMC_RST_MEAS;
    end else if (hit(req_in, SPMC_ADDR_MEAS_SELECT)) begin
      measurement_select <= req_in.wdata & SPMC_MASK_MEAS;
    end
  end

  // Bits 5:3 are kept read/write as printed even though they have no function
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flicker_buffer_config <= SPMC_RST_FLICK;
    end else if (hit(req_in, SPMC_ADDR_FLICK_CONFIG)) begin
      flicker_buffer_config <= req_in.wdata & SPMC_MASK_FLICK;
    end
  end

  // Adjust events are qualified by their auto-adjust enable; a set wins over a same-cycle clear
  assign base_evt = baseline_lowered_in & auto_baseline_on_in;
  assign offs_evt = offset_lowered_in & auto_offset_on_in;

  always_comb begin
    next_status = calibration_status;
    if (hit(req_in, SPMC_ADDR_CALIB_STATUS)) begin
      next_status = calibration_status & ~(req_in.wdata & SPMC_MASK_CALIB);
    end
    if (base_evt) begin
      next_status[SPMC_BIT_BASELINE] = 1'b1;
    end
    if (offs_evt) begin
      next_status[SPMC_BIT_OFFSET] = 1'b1;
    end
    if (calib_complete_in) begin
      next_status[SPMC_BIT_CALDONE] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      calibration_status <= SPMC_RST_CALIB;
    end else begin
      calibration_status <= next_status;
    end
  end

  // Calibration interrupt pulse for one cycle after a baseline or offset adjust event (one pulse if both come together) when enabled
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      calibration_interrupt_out <= 1'b0;
    end else begin
      calibration_interrupt_out <= calib_int_en_in & (base_evt | offs_evt);
    end
  end

  // Measurement start: immediate, or held off until the next sync edge
  assign any_on = function_enable[SPMC_BIT_POWER_ON] &
                  (function_enable[SPMC_BIT_LIGHT_ON] | function_enable[SPMC_BIT_PROX_ON] |
                   function_enable[SPMC_BIT_FLICK_ON]);

  always_comb begin
    next_state = state;
    unique case (state)
      SPMC_ST_IDLE: begin
        if (any_on) begin
          next_state = measurement_select[SPMC_BIT_SYNC] ? SPMC_ST_WAIT : SPMC_ST_RUN;
        end
      end
      SPMC_ST_WAIT: begin
        if (!any_on) begin
          next_state = SPMC_ST_IDLE;
        end else if (vsync_rise) begin
          next_state = SPMC_ST_RUN;
        end
      end
      SPMC_ST_RUN: begin
        if (!any_on) begin
          next_state = SPMC_ST_IDLE;
        end
      end
      default: next_state = SPMC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= SPMC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_out <= '0;
    end else begin
      ctrl_out.osc_run             <= function_enable[SPMC_BIT_POWER_ON];
      ctrl_out.flicker_on          <= function_enable[SPMC_BIT_FLICK_ON];
      ctrl_out.light_sense_on      <= function_enable[SPMC_BIT_LIGHT_ON];
      ctrl_out.prox_sense_on       <= function_enable[SPMC_BIT_PROX_ON];
      ctrl_out.measure_go          <= (state == SPMC_ST_RUN) && any_on;
      ctrl_out.prox_photodiode_on  <= (measurement_select[3:2] == SPMC_PROX_DIODE_ON);
      ctrl_out.light_chain_select  <= measurement_select[SPMC_BIT_CHAIN];
      ctrl_out.light_photodiode_on <= measurement_select[SPMC_BIT_LDIODE];
      ctrl_out.flicker_path_select <= flicker_buffer_config[SPMC_BIT_FPATH];
      ctrl_out.buf_fmt             <= flicker_buffer_config[2:0];
      ctrl_out.buf_fmt_bad         <= (flicker_buffer_config[2:0] > SPMC_BUF_FLICK8);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      calib_status_out <= SPMC_RST_CALIB;
    end else begin
      calib_status_out <= next_status;
    end
  end

  // Read port: one-cycle registered answer, unmapped addresses read zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out  <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd;
      if (req_in.rd) begin
        unique case (req_in.addr)
          SPMC_ADDR_CALIB_STATUS: rdata_out <= calibration_status;
          SPMC_ADDR_FUNC_ENABLE:  rdata_out <= function_enable;
          SPMC_ADDR_MEAS_SELECT:  rdata_out <= measurement_select;
          SPMC_ADDR_FLICK_CONFIG: rdata_out <= flicker_buffer_config;
          default:                rdata_out <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== testbench/spmc_regs_props.sv
// Assertions on the power, mode and calibration register ports.
// Bound to every spmc_regs instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module spmc_regs_props
  import spmc_pkg::*;
(
  input wire logic          clk_in,
  input wire logic          rst_in,
  input wire spmc_reg_req_s req_in,
  input wire logic          auto_baseline_on_in,
  input wire logic          auto_offset_on_in,
  input wire logic          calib_int_en_in,
  input wire logic          baseline_lowered_in,
  input wire logic          offset_lowered_in,
  input wire logic          calib_complete_in,
  input wire spmc_ctrl_s    ctrl_out,
  input wire logic [7:0]    calib_status_out,
  input wire logic          calibration_interrupt_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire w80 = req_in.wr && req_in.addr == 8'h80;
  wire w81 = req_in.wr && req_in.addr == 8'h81;
  wire w82 = req_in.wr && req_in.addr == 8'h82;
  property p_base; baseline_lowered_in && auto_baseline_on_in |=> calib_status_out[2]; endproperty
  a_base: assert property (p_base) else $error("baseline flag missed");
  property p_off; offset_lowered_in && auto_offset_on_in |=> calib_status_out[1]; endproperty
  a_off: assert property (p_off) else $error("offset flag missed");
  property p_done; calib_complete_in |=> calib_status_out[0]; endproperty
  a_done: assert property (p_done) else $error("done flag missed");
  property p_w1c;
    req_in.wr && req_in.addr == 8'h6D && req_in.wdata[0] && !calib_complete_in
      |=> !calib_status_out[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("done flag not cleared");
  property p_down;
    w80 && !req_in.wdata[0] |-> ##2
      !(ctrl_out.osc_run || ctrl_out.light_sense_on || ctrl_out.prox_sense_on);
  endproperty
  a_down: assert property (p_down) else $error("power off left functions on");
  property p_en;
    w80 && req_in.wdata[0] |-> ##2 {ctrl_out.osc_run, ctrl_out.flicker_on,
      ctrl_out.light_sense_on, ctrl_out.prox_sense_on} ==
      {1'b1, $past(req_in.wdata[6], 2), $past(req_in.wdata[4:3], 2)};
  endproperty
  a_en: assert property (p_en) else $error("enable bits wrong");
  property p_diode;
    w81 |-> ##2 {ctrl_out.prox_photodiode_on, ctrl_out.light_chain_select,
      ctrl_out.light_photodiode_on} ==
      {$past(req_in.wdata[3:2], 2) == 2'h3, $past(req_in.wdata[1:0], 2)};
  endproperty
  a_diode: assert property (p_diode) else $error("diode selection wrong");
  property p_fpath;
    w82 |-> ##2 {ctrl_out.flicker_path_select, ctrl_out.buf_fmt} ==
      $past({req_in.wdata[6], req_in.wdata[2:0]}, 2);
  endproperty
  a_fpath: assert property (p_fpath) else $error("flicker config wrong");
  property p_int;
    calib_int_en_in && (baseline_lowered_in && auto_baseline_on_in ||
      offset_lowered_in && auto_offset_on_in) |=> calibration_interrupt_out;
  endproperty
  a_int: assert property (p_int) else $error("interrupt missed");
endmodule
bind spmc_regs spmc_regs_props u_props (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
  .auto_baseline_on_in(auto_baseline_on_in), .auto_offset_on_in(auto_offset_on_in),
  .calib_int_en_in(calib_int_en_in), .baseline_lowered_in(baseline_lowered_in),
  .offset_lowered_in(offset_lowered_in), .calib_complete_in(calib_complete_in),
  .ctrl_out(ctrl_out), .calib_status_out(calib_status_out),
  .calibration_interrupt_out(calibration_interrupt_out));
`default_nettype wire

// ===== testbench/spmc_host.sv
// Host processor model issuing single-byte register writes and reads.
// Assumes the register port samples requests on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module spmc_host
  import spmc_pkg::*;
(
  input  wire logic         clk_in,
  output var spmc_reg_req_s req_out
);
  initial req_out = '0;
  // Idle address and data carry the inverse of the last byte, so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask
endmodule
`default_nettype wire

// ===== testbench/spmc_regs_tb_top.sv
// Self-checking bench for spmc_regs driven through the host model.
// Assumes spmc_host and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module spmc_regs_tb_top
  import spmc_pkg::*;
;
  logic          clk = 0;
  logic          rst = 1;
  logic          vsync, ab, ao, ien, bl, ol, cc, rvalid, irq;
  logic [7:0]    rdata, stat, d, exp_q[$];
  spmc_reg_req_s req;
  spmc_ctrl_s    ctrl;
  int            fail_count, n_compared, cyc;
  always #2 clk = ~clk;
  spmc_host u_host (.clk_in(clk), .req_out(req));
  spmc_regs u_dut (.clk_in(clk), .rst_in(rst), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .vsync_in(vsync), .auto_baseline_on_in(ab), .auto_offset_on_in(ao),
    .calib_int_en_in(ien), .baseline_lowered_in(bl), .offset_lowered_in(ol),
    .calib_complete_in(cc), .ctrl_out(ctrl), .calib_status_out(stat),
    .calibration_interrupt_out(irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host.xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // The interrupt stands for one cycle only, so it is looked at right after the event edge
  task automatic events(input logic [2:0] en, input logic [2:0] ev, input logic e,
                        input logic [7:0] s);
    @(posedge clk);
    {ab, ao, ien} <= en;
    {bl, ol, cc} <= ev;
    @(posedge clk);
    {bl, ol, cc} <= 3'h0;
    #1;
    check({7'h0, irq}, {7'h0, e});
    check(stat, s);
    @(posedge clk);
    #1;
    check({7'h0, irq}, 8'h00);
  endtask
  task automatic wait_go(input logic e);
    for (int k = 0; k < 12 && ctrl.measure_go !== e; k++) begin
      @(posedge clk);
      #1;
    end
    check({7'h0, ctrl.measure_go}, {7'h0, e});
  endtask
  always @(posedge clk) begin
    if (rvalid === 1'b1) check(rdata, exp_q.pop_front());
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    {vsync, ab, ao, ien, bl, ol, cc} = '0;
    void'($urandom(5));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (SPMC_RST_CALIB[i]) rd(i == 0 ? 8'h83 : 8'h6D, 8'h00);
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    rd(8'h82, 8'h00);
    $display("reset test done");
    d = 8'($urandom);
    wr(8'h80, 8'h01);
    wr(8'h80, d | 8'h01);
    settle;
    check({4'h0, ctrl.osc_run, ctrl.flicker_on, ctrl.light_sense_on, ctrl.prox_sense_on},
      {4'h0, 1'b1, d[6], d[4:3]});
    rd(8'h80, (d | 8'h01) & 8'h59);
    wr(8'h80, d & 8'hFE);
    settle;
    check({4'h0, ctrl.osc_run, ctrl.flicker_on, ctrl.light_sense_on, ctrl.prox_sense_on},
      {5'h0, d[6], 2'h0});
    rd(8'h80, d & 8'h40);
    $display("power test done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      d[3:2] = 2'(i);
      wr(8'h81, d);
      settle;
      check({5'h0, ctrl.prox_photodiode_on, ctrl.light_chain_select, ctrl.light_photodiode_on},
        {5'h0, i == 3, d[1:0]});
      rd(8'h81, d & 8'h4F);
    end
    $display("measurement select test done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      d[2:0] = 3'(i);
      wr(8'h82, d);
      settle;
      check({3'h0, ctrl.flicker_path_select, ctrl.buf_fmt, ctrl.buf_fmt_bad},
        {3'h0, d[6], d[2:0], i > 4});
      rd(8'h82, d & 8'h7F);
    end
    $display("flicker config test done");
    events(3'b001, 3'b111, 1'b0, 8'h01);
    rd(8'h6D, 8'h01);
    wr(8'h6D, 8'hFE);
    rd(8'h6D, 8'h01);
    wr(8'h6D, 8'h01);
    rd(8'h6D, 8'h00);
    events(3'b111, 3'b100, 1'b1, 8'h04);
    events(3'b111, 3'b010, 1'b1, 8'h06);
    events(3'b110, 3'b111, 1'b0, 8'h07);
    rd(8'h6D, 8'h07);
    wr(8'h6D, 8'h02);
    rd(8'h6D, 8'h05);
    wr(8'h6D, 8'h05);
    rd(8'h6D, 8'h00);
    $display("calibration flag test done");
    wr(8'h80, 8'h00);
    wr(8'h82, 8'h00);
    wr(8'h81, 8'h40);
    wr(8'h80, 8'h01);
    wr(8'h80, 8'h11);
    repeat (8) @(posedge clk);
    #1;
    check({7'h0, ctrl.measure_go}, 8'h00);
    @(posedge clk);
    vsync <= 1'b1;
    wait_go(1'b1);
    @(posedge clk);
    vsync <= 1'b0;
    wr(8'h80, 8'h00);
    wait_go(1'b0);
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h01);
    wr(8'h80, 8'h19);
    wait_go(1'b1);
    $display("sync start test done");
    repeat (4) @(posedge clk);
    wrap_up;
  end
endmodule
`default_nettype wire
